// ===== dv/ffps_power_stage.sv
/* Power stage stand-in: free-running switching cycle of 8 clocks and current sense.
   Assumes the bench sets overLoad off the clock edge. */
`timescale 1ns/1ns
`default_nettype none
module ffps_power_stage (
   input wire logic clk, // Clock.
   input wire logic overLoad, // Sense above the over-current level.
   output logic [11:0] currentSense, // Sense, mV.
   output logic senseWindow, // Sampling window.
   output logic cycleEnd // Cycle end pulse.
);
   logic [2:0] phase = 3'h0;
   // Cycle phase counter.
   always_ff @(posedge clk) begin
      phase <= phase + 3'h1;
   end
   // Outside the window the sense shows a moving low pattern, so nothing leans on a held value.
   assign senseWindow = phase inside {3'h4, 3'h5};
   assign cycleEnd = phase == 3'h7;
   assign currentSense = !senseWindow ? {9'h000, phase} : (overLoad ? 12'h514 : 12'h12C);
endmodule : ffps_power_stage
`default_nettype wire

// ===== dv/ffps_seq_sva.sv
/* Port checker for the fault sequencer.
   Assumes it is bound to the sequencer; a low ce only freezes what it watches. */
`timescale 1ns/1ns
`default_nettype none
module ffps_seq_sva #(parameter int OPP_CYCLES = 20, parameter int LC_GAIN = 16, parameter int LC_W = 12) (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire ffps_pkg::ffps_supply_t supplyPins, // Status pins.
   input wire logic [11:0] peakCurrentThreshold, // Threshold.
   input wire logic [LC_W-1:0] lineSenseCurrent, // Line current.
   input wire logic gateRequest, // Gate request.
   input wire logic lowSideGateDrive, // Gate.
   input wire logic runOut, // Run.
   input wire logic [11:0] overPowerThreshold, // Level.
   input wire logic [11:0] maxPeakCurrentThreshold, // Clamp.
   input wire logic [LC_W-1:0] lineCompCurrent, // Comp current.
   input wire logic faultActive, // Fault wait.
   input wire logic ocpFault // Over-current.
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] hiCnt;
   // Running cycles above the level; slack of four covers the sync and output stages.
   always_ff @(posedge clk) begin
      if (rst || !runOut || peakCurrentThreshold <= overPowerThreshold) begin
         hiCnt <= 32'h0000_0000;
      end else begin
         hiCnt <= hiCnt + 32'h0000_0001;
      end
   end
   opp_time_a: assert property (hiCnt <= OPP_CYCLES + 4) else $error("over-power run too long");
   opp_cap_a: assert property (overPowerThreshold <= 12'h258) else $error("level above top");
   ppl_ratio_a: assert property ($stable(overPowerThreshold) [*4] |-> (16'(maxPeakCurrentThreshold) * 16'h0003 <=
      16'(overPowerThreshold) * 16'h0004) && (16'(maxPeakCurrentThreshold) * 16'h0003 + 16'h0018 >=
      16'(overPowerThreshold) * 16'h0004)) else $error("clamp not near four thirds");
   line_comp_a: assert property ($stable(lineSenseCurrent) [*3] |-> lineCompCurrent == lineSenseCurrent / LC_GAIN)
      else $error("line comp off");
   fault_gate_a: assert property (faultActive |-> !lowSideGateDrive && !runOut) else $error("switching in fault");
   gate_req_a: assert property (lowSideGateDrive |-> $past(gateRequest) && runOut) else $error("stray gate");
   ocp_stop_a: assert property ($rose(ocpFault) |-> ##[0:2] !runOut) else $error("run after over-current");
   ref_low_a: assert property (!supplyPins.refGood [*5] |-> !runOut) else $error("run with reference low");
   hot_stop_a: assert property (supplyPins.overTemp [*5] |-> !runOut) else $error("run while hot");
endmodule : ffps_seq_sva
`default_nettype wire

// ===== dv/tb_top.sv
/* Self-checking bench for the fault sequencer.
   Assumes shortened timer parameters and a free-running power stage model. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int OPPN = 20;
   localparam int FDRN = 30;
   logic clk = 1'b0, rst = 1'b1, gateReq = 1'b0, overLoad = 1'b0, win, cend, gate, runOut, fault, over_current_protection;
   ffps_pkg::ffps_supply_t pins = 4'h0;
   logic ceOn = 1'b1; // Clock enable, dropped once to check the freeze.
   logic [11:0] peak = 12'h000, vs = 12'hBB8, level = 12'h1F4, lineI = 12'h000, cs, oppThr, maxThr, lcI;
   int fail_count = 0, check_count = 0, s;
   logic [11:0] expQ[$], seen[6];
   int selQ[$];
   string names[6] = '{"run", "gate", "fault", "ocp", "threshold", "linecomp"};
   assign seen[0] = {11'h000, runOut};
   assign seen[1] = {11'h000, gate};
   assign seen[2] = {11'h000, fault};
   assign seen[3] = {11'h000, over_current_protection};
   assign seen[4] = oppThr;
   assign seen[5] = lcI;
   always #2 clk = ~clk;
   ffps_power_stage ps_u (.clk(clk), .overLoad(overLoad), .currentSense(cs), .senseWindow(win), .cycleEnd(cend));
   ffps_sequencer #(.OPP_CYCLES(OPPN), .FDR_CYCLES(FDRN)) dut_u (.clk(clk), .rst(rst), .ce(ceOn), .supplyPins(pins),
      .peakCurrentThreshold(peak), .outputVoltageSense(vs), .currentSense(cs), .oppCurveLevel(level),
      .lineSenseCurrent(lineI), .senseWindow(win), .cycleEnd(cend), .gateRequest(gateReq), .lowSideGateDrive(gate),
      .runOut(runOut), .overPowerThreshold(oppThr), .maxPeakCurrentThreshold(maxThr), .lineCompCurrent(lcI),
      .faultActive(fault), .ocpFault(over_current_protection));
   task automatic complete_run();
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic compare(input string nm, input logic [11:0] x, input logic [11:0] g);
      check_count++;
      if (g !== x) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask : compare
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic note(input int sel, input logic [11:0] x);
      selQ.push_back(sel);
      expQ.push_back(x);
   endtask : note
   // Bounded wait; running out of the bound counts as a mismatch and ends the run.
   task automatic wait_for(input int sel, input logic x, input int n);
      int i;
      i = 0;
      while (seen[sel][0] !== x && i < n) begin
         tick(1);
         i++;
      end
      if (seen[sel][0] !== x) begin
         fail_count++;
         complete_run();
      end
   endtask : wait_for
   task automatic supply_cycle();
      pins.supplyOn = 1'b0;
      pins.supplyOff = 1'b1;
      tick(3);
      pins.supplyOff = 1'b0;
      pins.supplyOn = 1'b1;
   endtask : supply_cycle
   // Results are compared at the next falling edge, a quarter cycle after each note, once the design's updates have landed.
   always @(negedge clk) begin
      while (selQ.size() > 0) begin
         s = selQ.pop_front();
         compare(names[s], expQ.pop_front(), seen[s]);
      end
   end
   initial begin
      void'($urandom(87096));
      tick(12);
      rst = 1'b0;
      note(0, 12'h000);
      pins = 4'h9;
      wait_for(0, 1'b1, 12);
      gateReq = 1'b1;
      for (int k = 0; k < 4; k++) begin
         lineI = 12'($urandom);
         tick(5);
         note(5, lineI / 12'h010);
      end
      peak = 12'h1F5;
      tick(OPPN - 4);
      peak = 12'h000;
      tick(OPPN);
      note(2, 12'h000);
      note(1, 12'h001);
      note(4, 12'h01F4);
      peak = 12'h3E8;
      tick(OPPN - 4);
      note(2, 12'h000);
      wait_for(2, 1'b1, 8);
      peak = 12'h000;
      tick(2);
      note(1, 12'h000);
      supply_cycle();
      tick(2);
      note(2, 12'h001);
      tick(FDRN);
      supply_cycle();
      wait_for(0, 1'b1, 20);
      vs = 12'h190;
      supply_cycle();
      tick(2);
      note(2, 12'h001);
      note(4, 12'h0177);
      vs = 12'hBB8;
      tick(FDRN);
      supply_cycle();
      wait_for(0, 1'b1, 20);
      supply_cycle();
      tick(2);
      note(0, 12'h000);
      note(2, 12'h000);
      wait_for(0, 1'b1, 20);
      overLoad = 1'b1;
      tick(12);
      note(3, 12'h000);
      wait_for(3, 1'b1, 30);
      overLoad = 1'b0;
      tick(2);
      note(0, 12'h000);
      tick(FDRN);
      supply_cycle();
      wait_for(0, 1'b1, 20);
      note(3, 12'h000);
      pins.refGood = 1'b0;
      tick(6);
      note(1, 12'h000);
      supply_cycle();
      tick(6);
      note(0, 12'h000);
      pins.refGood = 1'b1;
      wait_for(0, 1'b1, 20);
      pins.overTemp = 1'b1;
      tick(6);
      note(0, 12'h000);
      supply_cycle();
      tick(6);
      note(0, 12'h000);
      pins.overTemp = 1'b0;
      wait_for(0, 1'b1, 20);
      tick(2);
      // A level above the top point is held back while the clock enable is low, then capped.
      ceOn = 1'b0;
      level = 12'h3E8;
      tick(4);
      note(4, 12'h01F4);
      ceOn = 1'b1;
      tick(3);
      note(4, 12'h0258);
      tick(1);
      complete_run();
   end
endmodule : tb_top
bind ffps_sequencer ffps_seq_sva #(.OPP_CYCLES(OPP_CYCLES), .LC_GAIN(LC_GAIN), .LC_W(LC_W)) chk_u (.clk(clk),
   .rst(rst), .supplyPins(supplyPins), .peakCurrentThreshold(peakCurrentThreshold),
   .lineSenseCurrent(lineSenseCurrent), .gateRequest(gateRequest), .lowSideGateDrive(lowSideGateDrive),
   .runOut(runOut), .overPowerThreshold(overPowerThreshold), .maxPeakCurrentThreshold(maxPeakCurrentThreshold),
   .lineCompCurrent(lineCompCurrent), .faultActive(faultActive), .ocpFault(ocpFault));
`default_nettype wire

// ===== rtl/ffps_consts.svh
/*
 Constants for the flyback fault-protection sequencer: timing counts and threshold codes.
 Assumes a 250 MHz core clock and 12-bit millivolt-scaled comparator codes.
*/
`ifndef FFPS_CONSTS_SVH
`define FFPS_CONSTS_SVH
`define FFPS_CLK_MHZ 250
`define FFPS_OPP_TIME_MS 160
`define FFPS_OPP_CYCLES (`FFPS_OPP_TIME_MS * 1000 * `FFPS_CLK_MHZ)
`define FFPS_FDR_TIME_MS 1500
`define FFPS_FDR_CYCLES (`FFPS_FDR_TIME_MS * 1000 * `FFPS_CLK_MHZ)
`define FFPS_OCP_CYCLES_MAX 3
// Voltages in millivolts.
`define FFPS_VS_HIGH_MV 12'h09C4
`define FFPS_VS_LOW_MV 12'h0960
`define FFPS_VS_SHORT_MV 12'h01F4
`define FFPS_OPP_TOP_MV 12'h0258
`define FFPS_OCP_MV 12'h04B0
`endif

// ===== rtl/ffps_pkg.sv
/*
 Types for the flyback fault-protection sequencer.
 Assumes the constants header is available to its users.
*/
package ffps_pkg;
   typedef enum logic [3:0] {
      FFPS_RUN = 4'b0001,
      FFPS_UV_RESTART = 4'b0010,
      FFPS_FAULT_WAIT = 4'b0100,
      FFPS_FAULT_DONE = 4'b1000
   } ffps_state_t;
   typedef struct packed {
      logic refGood;
      logic overTemp;
      logic supplyOff;
      logic supplyOn;
   } ffps_supply_t;
endpackage : ffps_pkg

// ===== rtl/ffps_sequencer.sv
/*
 Fault-protection sequencer for a flyback controller: over-power timing, peak power limit,
 output short detection, over-current counting, external and thermal shutdown.
 Assumes analog levels arrive as millivolt codes already on this clock; status pins are asynchronous.
*/
`include "ffps_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ffps_sequencer #(
   parameter int OPP_CYCLES = `FFPS_OPP_CYCLES, // Over-power timeout count.
   parameter int FDR_CYCLES = `FFPS_FDR_CYCLES, // Recovery wait count.
   parameter int LC_GAIN = 16, // Line-compensation gain divisor.
   parameter int LC_W = 12 // Line current code width.
) (
   input wire logic clk, // Core clock.
   input wire logic rst, // Synchronous reset, held by supply lockout.
   input wire logic ce, // Clock enable.
   input wire ffps_pkg::ffps_supply_t supplyPins, // Asynchronous supply and status pins.
   input wire logic [11:0] peakCurrentThreshold, // Commanded peak-current threshold, mV.
   input wire logic [11:0] outputVoltageSense, // Output sense level, mV.
   input wire logic [11:0] currentSense, // Current-sense level, mV.
   input wire logic [11:0] oppCurveLevel, // Line-dependent curve level, mV.
   input wire logic [LC_W-1:0] lineSenseCurrent, // Line-sense current code.
   input wire logic senseWindow, // High after blanking until demagnetization ends.
   input wire logic cycleEnd, // Pulse at end of each low-side cycle.
   input wire logic gateRequest, // Gate request from the current loop.
   output logic lowSideGateDrive, // Gated low-side drive.
   output logic runOut, // Run pin level.
   output logic [11:0] overPowerThreshold, // Active over-power threshold.
   output logic [11:0] maxPeakCurrentThreshold, // Peak power limit clamp.
   output logic [LC_W-1:0] lineCompCurrent, // Line-compensation source code.
   output logic faultActive, // Long recovery fault is pending.
   output logic ocpFault // Over-current fault flag.
);
   ffps_pkg::ffps_supply_t sync1;
   ffps_pkg::ffps_supply_t sync2;
   ffps_pkg::ffps_state_t state;
   logic highCurve;
   logic [31:0] oppCount;
   logic [31:0] fdrCount;
   logic [1:0] ocpCount;
   logic oppTimeout;
   logic overOpp; // Commanded peak above the active over-power level.
   logic overOcp; // Sense above the over-current level inside the window.
   logic shortAtOff;
   logic [11:0] curve;
   logic [13:0] maxCalc;

   // One comparison shared by the over-power and over-current checks, so both agree on strictness.
   function automatic logic ffps_above(input logic [11:0] level, input logic [11:0] limit);
      return level > limit;
   endfunction : ffps_above

   // Pins cross into the clock domain through two flops.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (ce) begin
         sync1 <= supplyPins;
         sync2 <= sync1;
      end
   end

   // Hysteresis between the two thresholds avoids curve chatter near 2.45 V.
   always_ff @(posedge clk) begin
      if (rst) begin
         highCurve <= 1'b0;
      end else if (ce) begin
         if (outputVoltageSense > `FFPS_VS_HIGH_MV) begin
            highCurve <= 1'b1;
         end else if (outputVoltageSense < `FFPS_VS_LOW_MV) begin
            highCurve <= 1'b0;
         end
      end
   end

   // The low set is the curve level lowered by one quarter; both are capped at the top point.
   always_comb begin
      curve = highCurve ? oppCurveLevel : (oppCurveLevel - {2'b00, oppCurveLevel[11:2]});
      if (curve > `FFPS_OPP_TOP_MV) begin
         curve = `FFPS_OPP_TOP_MV;
      end
      maxCalc = {2'b00, curve} + {4'b0000, curve[11:2]} + {6'b000000, curve[11:4]} + {8'h00, curve[11:6]};
   end

   // Threshold and compensation outputs are registered.
   always_ff @(posedge clk) begin
      if (rst) begin
         overPowerThreshold <= `FFPS_OPP_TOP_MV;
         maxPeakCurrentThreshold <= 12'h0000;
         lineCompCurrent <= '0;
      end else if (ce) begin
         overPowerThreshold <= curve;
         maxPeakCurrentThreshold <= maxCalc[11:0];
         lineCompCurrent <= LC_W'(lineSenseCurrent / LC_GAIN);
      end
   end

   // Both limits are strict, so a level sitting exactly on a limit is never a fault.
   assign overOpp = ffps_above(peakCurrentThreshold, overPowerThreshold);
   assign overOcp = senseWindow && ffps_above(currentSense, `FFPS_OCP_MV);

   // The timeout fires on the last counted cycle only if the level is still exceeded then.
   assign oppTimeout = (oppCount >= 32'(OPP_CYCLES - 1)) && overOpp;
   // The short check looks at both the threshold and a collapsed output at turn-off.
   assign shortAtOff = overOpp || (outputVoltageSense < `FFPS_VS_SHORT_MV);

   // Over-power timer, only counting while running.
   always_ff @(posedge clk) begin
      if (rst) begin
         oppCount <= 32'h0000_0000;
      end else if (ce) begin
         if (state == ffps_pkg::FFPS_RUN && overOpp) begin
            oppCount <= oppCount + 32'h0000_0001;
         end else begin
            oppCount <= 32'h0000_0000;
         end
      end
   end

   // Consecutive over-current cycle counter; a clean cycle restarts the count.
   logic ocpSeen;
   always_ff @(posedge clk) begin
      if (rst) begin
         ocpSeen <= 1'b0;
         ocpCount <= 2'b00;
      end else if (ce) begin
         if (cycleEnd || state != ffps_pkg::FFPS_RUN) begin
            ocpSeen <= 1'b0;
         end else if (overOcp) begin
            ocpSeen <= 1'b1;
         end
         if (state != ffps_pkg::FFPS_RUN) begin
            ocpCount <= 2'b00;
         end else if (cycleEnd) begin
            ocpCount <= (ocpSeen || overOcp) ? ocpCount + 2'b01 : 2'b00;
         end
      end
   end

   logic ocpHit;
   assign ocpHit = cycleEnd && (ocpCount == 2'(`FFPS_OCP_CYCLES_MAX - 1))
                   && (ocpSeen || overOcp);

   // Main sequence. Restarts leave via supply-on, fault waits via turn-off after the wait.
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ffps_pkg::FFPS_UV_RESTART;
         fdrCount <= 32'h0000_0000;
      end else if (ce) begin
         case (state)
            ffps_pkg::FFPS_RUN: begin
               fdrCount <= 32'h0000_0000;
               if (oppTimeout || ocpHit) begin
                  state <= ffps_pkg::FFPS_FAULT_WAIT;
               end else if (sync2.supplyOff && shortAtOff) begin
                  state <= ffps_pkg::FFPS_FAULT_WAIT;
               end else if (sync2.supplyOff || !sync2.refGood || sync2.overTemp) begin
                  state <= ffps_pkg::FFPS_UV_RESTART;
               end
            end
            ffps_pkg::FFPS_UV_RESTART: begin
               // Reference held low or still hot keeps the device here each cycle.
               if (sync2.supplyOn && sync2.refGood && !sync2.overTemp) begin
                  state <= ffps_pkg::FFPS_RUN;
               end
            end
            ffps_pkg::FFPS_FAULT_WAIT: begin
               if (fdrCount >= 32'(FDR_CYCLES - 1)) begin
                  state <= ffps_pkg::FFPS_FAULT_DONE;
               end else begin
                  fdrCount <= fdrCount + 32'h0000_0001;
               end
            end
            ffps_pkg::FFPS_FAULT_DONE: begin
               if (sync2.supplyOff) begin
                  state <= ffps_pkg::FFPS_UV_RESTART;
               end
            end
            default: begin
               state <= ffps_pkg::FFPS_UV_RESTART;
            end
         endcase
      end
   end

   // Outputs: gating only in run, so fault waits never emit test pulses.
   always_ff @(posedge clk) begin
      if (rst) begin
         lowSideGateDrive <= 1'b0;
         runOut <= 1'b0;
         faultActive <= 1'b0;
         ocpFault <= 1'b0;
      end else if (ce) begin
         lowSideGateDrive <= (state == ffps_pkg::FFPS_RUN) && gateRequest && sync2.refGood && !ocpHit;
         runOut <= (state == ffps_pkg::FFPS_RUN) && !ocpHit;
         faultActive <= (state == ffps_pkg::FFPS_FAULT_WAIT) || (state == ffps_pkg::FFPS_FAULT_DONE);
         // A hit in the same cycle as the restart clear wins, so a fault is never lost.
         if (ocpHit) begin
            ocpFault <= 1'b1;
         end else if (state == ffps_pkg::FFPS_UV_RESTART) begin
            ocpFault <= 1'b0;
         end
      end
   end
endmodule : ffps_sequencer
`default_nettype wire
